//--- hw/rraddr_pkg.sv
package rraddr_pkg;
    localparam int RRADDR_PC_W       = 12;
    localparam int RRADDR_RAM_W      = 10;
    localparam int RRADDR_ROM_W      = 10;
    localparam int RRADDR_PAGE_LSB   = 8;
    localparam int RRADDR_PAGES      = 8;
    localparam int RRADDR_PAGE_WORDS = 256;
    localparam int RRADDR_ZP_W       = 6;
    localparam int RRADDR_RO8_BIT    = 8;
    localparam int RRADDR_RO9_BIT    = 9;
    localparam logic [9:0]  RRADDR_MEMREG_BASE = 10'h020;
    localparam logic [11:0] RRADDR_PC_RESET    = 12'h000;
    localparam logic [3:0]  RRADDR_NIB_RESET   = 4'h0;

    typedef enum logic [2:0] {
        RRADDR_RAM_NONE     = 3'h0,
        RRADDR_RAM_INDIRECT = 3'h1,
        RRADDR_RAM_DIRECT   = 3'h2,
        RRADDR_RAM_MEMREG   = 3'h3
    } rraddr_ram_mode_t;

    typedef enum logic [2:0] {
        RRADDR_OP_SEQ        = 3'h0,
        RRADDR_OP_LONG_JUMP  = 3'h1,
        RRADDR_OP_PAGE_JUMP  = 3'h2,
        RRADDR_OP_ZERO_PAGE  = 3'h3,
        RRADDR_OP_TABLE_GOTO = 3'h4,
        RRADDR_OP_TABLE_READ = 3'h5
    } rraddr_pc_op_t;
endpackage

//--- hw/rraddr_ram.sv
`timescale 1ns/1ps
module rraddr_ram
    import rraddr_pkg::*;
(
    input  wire logic [2:0] ram_mode,
    input  wire logic [3:0] x_reg,
    input  wire logic [3:0] y_reg,
    input  wire logic [9:0] second_word,
    input  wire logic [3:0] memreg_idx,
    output logic      [9:0] ram_addr
);
    wire [9:0] indirect_addr = {2'h0, x_reg, y_reg};         // see RULE1
    wire [9:0] memreg_addr   = RRADDR_MEMREG_BASE | {6'h00, memreg_idx}; // see RULE3
    wire       is_ind        = ram_mode == RRADDR_RAM_INDIRECT;
    wire       is_dir        = ram_mode == RRADDR_RAM_DIRECT;
    wire       is_mr         = ram_mode == RRADDR_RAM_MEMREG;
    assign ram_addr = is_ind ? indirect_addr :
                      is_dir ? second_word :                 // see RULE2
                      is_mr  ? memreg_addr : 10'h000;
endmodule // rraddr_ram

//--- hw/rraddr_core.sv
`timescale 1ns/1ps
// How it works
// RULE1: Indirect RAM address is the 8 bits of the two select registers.
// RULE2: Direct RAM access uses the whole 10-bit second word as address.
// RULE3: Memory-register access hits the 16 digits at 020 to 02F.
// RULE4: Long jumps load all 12 pointer bits from the immediate.
// RULE5: ROM is 8 pages of 256 words; high bits page, low bits word.
// RULE6: Page jump replaces bits 7..0 only and keeps the page bits; the code also clears pointer bit 11.
// RULE7: A page jump at a page's last word lands on the next page.
// RULE8: Zero-page call puts 6 bits in 5..0 and clears bits 11..6.
// RULE9: Table goto target comes from immediate, accumulator and aux register.
// RULE10: Readout with bit 8 set loads the low byte into accumulator and aux.
// RULE11: Readout with bit 9 set loads the low byte into both port latches.
// RULE12: With both bits set all four destinations update together.
// RULE13: Table readout leaves the pointer stepping sequentially.
// RULE14: Table address is immediate high, then accumulator, then aux low.
module rraddr_core
    import rraddr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        step_en,
    input  wire logic [2:0]  pc_op,
    input  wire logic [11:0] imm,
    input  wire logic [2:0]  ram_mode,
    input  wire logic [3:0]  x_reg,
    input  wire logic [3:0]  y_reg,
    input  wire logic [9:0]  second_word,
    input  wire logic [3:0]  memreg_idx,
    input  wire logic [3:0]  acc_in,
    input  wire logic [3:0]  aux_in,
    input  wire logic [9:0]  rom_data,
    output logic      [11:0] instr_pointer,
    output logic      [11:0] rom_addr,
    output logic      [9:0]  ram_addr,
    output logic      [3:0]  acc_out,
    output logic      [3:0]  aux_out,
    output logic             acc_aux_load,
    output logic      [3:0]  output_latch_one,
    output logic      [3:0]  output_latch_two
);
    logic [11:0] pc_r;
    logic [11:0] pc_nxt;
    logic [3:0]  acc_r;
    logic [3:0]  aux_r;
    logic        ld_r;
    logic [3:0]  lat1_r;
    logic [3:0]  lat2_r;

    // Pointer already advanced when the jump executes, hence page slip
    wire [11:0] pc_inc    = pc_r + 12'h001;
    wire [2:0]  cur_page  = pc_inc[10:RRADDR_PAGE_LSB];              // see RULE5
    wire [11:0] page_tgt  = {1'b0, cur_page, imm[7:0]};              // see RULE6, see RULE7
    wire [11:0] zp_tgt    = {6'h00, imm[5:0]};                       // see RULE8
    wire [11:0] tbl_tgt   = {imm[3:0], acc_in, aux_in};              // see RULE9, see RULE14
    wire        is_long   = pc_op == RRADDR_OP_LONG_JUMP;
    wire        is_page   = pc_op == RRADDR_OP_PAGE_JUMP;
    wire        is_zp     = pc_op == RRADDR_OP_ZERO_PAGE;
    wire        is_tgoto  = pc_op == RRADDR_OP_TABLE_GOTO;
    wire        is_tread  = pc_op == RRADDR_OP_TABLE_READ;
    wire        rom_b8    = rom_data[RRADDR_RO8_BIT];
    wire        rom_b9    = rom_data[RRADDR_RO9_BIT];
    wire        rom_bit_eight_flag = is_tread & rom_b8;              // see RULE10
    wire        rom_bit_nine_flag  = is_tread & rom_b9;              // see RULE11

    assign pc_nxt = is_long  ? imm :                                 // see RULE4
                    is_page  ? page_tgt :
                    is_zp    ? zp_tgt :
                    is_tgoto ? tbl_tgt : pc_inc;                     // see RULE13

    // Readout fetches the table word while the pointer steps on to the next word
    assign rom_addr = is_tread ? tbl_tgt : pc_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pc_r <= RRADDR_PC_RESET;
        end else if (step_en) begin
            pc_r <= pc_nxt;
        end
    end

    // Both flags act in the same step when both are set
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            acc_r  <= RRADDR_NIB_RESET;
            aux_r  <= RRADDR_NIB_RESET;
            ld_r   <= 1'b0;
            lat1_r <= RRADDR_NIB_RESET;
            lat2_r <= RRADDR_NIB_RESET;
        end else begin
            ld_r <= step_en & rom_bit_eight_flag;
            if (step_en && rom_bit_eight_flag) begin
                acc_r <= rom_data[7:4];                              // see RULE10, see RULE12
                aux_r <= rom_data[3:0];
            end
            if (step_en && rom_bit_nine_flag) begin
                lat1_r <= rom_data[7:4];                             // see RULE11, see RULE12
                lat2_r <= rom_data[3:0];
            end
        end
    end

    rraddr_ram u_ram (
        .ram_mode    (ram_mode),
        .x_reg       (x_reg),
        .y_reg       (y_reg),
        .second_word (second_word),
        .memreg_idx  (memreg_idx),
        .ram_addr    (ram_addr)
    );

    assign instr_pointer    = pc_r;
    assign acc_out          = acc_r;
    assign aux_out          = aux_r;
    assign acc_aux_load     = ld_r;
    assign output_latch_one = lat1_r;
    assign output_latch_two = lat2_r;
endmodule // rraddr_core

//--- testbench/rraddr_core_asserts.sv
`timescale 1ns/1ps
module rraddr_core_asserts
    import rraddr_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        step_en,
    input wire logic        acc_aux_load,
    input wire logic [2:0]  pc_op,
    input wire logic [2:0]  ram_mode,
    input wire logic [3:0]  x_reg,
    input wire logic [3:0]  y_reg,
    input wire logic [3:0]  memreg_idx,
    input wire logic [3:0]  acc_in,
    input wire logic [3:0]  aux_in,
    input wire logic [3:0]  acc_out,
    input wire logic [9:0]  second_word,
    input wire logic [9:0]  rom_data,
    input wire logic [9:0]  ram_addr,
    input wire logic [11:0] imm,
    input wire logic [11:0] instr_pointer
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire [11:0] pc_inc = instr_pointer + 12'h001;
    sequence s_rd; step_en && pc_op == 3'h5; endsequence
    a_ram_ind: assert property (ram_mode == 3'h1 |-> ram_addr == {2'h0, x_reg, y_reg})
        else $error("indirect");
    a_ram_dir: assert property (ram_mode == 3'h2 |-> ram_addr == second_word)
        else $error("direct");
    a_ram_memreg: assert property (ram_mode == 3'h3 |-> ram_addr == {6'h02, memreg_idx})
        else $error("memreg");
    a_long_jump: assert property (step_en && pc_op == 3'h1 |=> instr_pointer == $past(imm))
        else $error("long");
    a_page_jump: assert property (step_en && pc_op == 3'h2 |=>
        instr_pointer == {1'b0, $past(pc_inc[10:8]), $past(imm[7:0])}) else $error("page");
    a_table_goto: assert property (step_en && pc_op == 3'h4 |=>
        instr_pointer == {$past(imm[3:0]), $past(acc_in), $past(aux_in)}) else $error("goto");
    a_read_seq: assert property (s_rd |=> instr_pointer == $past(pc_inc))
        else $error("read pc");
    a_read_acc: assert property (s_rd ##0 rom_data[8] |=>
        acc_aux_load && acc_out == $past(rom_data[7:4])) else $error("read acc");
endmodule // rraddr_core_asserts

//--- testbench/rraddr_rom_model.sv
`timescale 1ns/1ps
module rraddr_rom_model (
    input  wire logic [11:0] rom_addr,
    output logic      [9:0]  rom_data
);
    // Flags follow the accumulator bits of the table address, so all four pairs are reachable
    assign rom_data = {rom_addr[5:4], ~rom_addr[7:0]};
endmodule // rraddr_rom_model

//--- testbench/tb_ram_rom_address_generation.sv
`timescale 1ns/1ps
module tb_ram_rom_address_generation;
    logic        mclk = 1'b0, rst_n = 1'b0, step_en = 1'b0, acc_aux_load;
    logic [2:0]  pc_op = 3'h0, ram_mode = 3'h0;
    logic [3:0]  x_reg = 4'h9, y_reg = 4'h6, memreg_idx = 4'hf, acc_in = 4'h0, aux_in = 4'h4;
    logic [3:0]  acc_out, aux_out, output_latch_one, output_latch_two;
    logic [9:0]  second_word = 10'h3c5, rom_data, ram_addr;
    logic [11:0] imm = 12'h000, instr_pointer, rom_addr;
    int          n_errors = 0, num_checks = 0;
    always #20 mclk = ~mclk;
    rraddr_rom_model i_rraddr_rom_model (.rom_addr(rom_addr), .rom_data(rom_data));
    rraddr_core i_rraddr_core (.*);
    task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic step(logic [2:0] op, logic [11:0] v, logic [3:0] a);
        @(posedge mclk);
        step_en <= 1'b1;
        pc_op <= op;
        imm <= v;
        acc_in <= a;
        @(posedge mclk);
        step_en <= 1'b0;
        #1;
    endtask
    task automatic t_ram();
        logic [11:0] ex[3] = '{12'h096, 12'h3c5, 12'h02f};
        for (int m = 1; m < 4; m++) begin
            @(posedge mclk);
            ram_mode <= 3'(m);
            #1;
            chk("ram_addr", {2'h0, ram_addr}, ex[m-1]);
        end
    endtask
    task automatic t_jump();
        step(3'h1, 12'h0ff, 4'h3);
        chk("long", instr_pointer, 12'h0ff);
        step(3'h2, 12'h012, 4'h3);
        chk("edge", instr_pointer, 12'h112);
        step(3'h2, 12'h0a7, 4'h3);
        chk("page", instr_pointer, 12'h1a7);
        step(3'h3, 12'hfff, 4'h3);
        chk("zero", instr_pointer, 12'h03f);
        step(3'h4, 12'h00a, 4'h3);
        repeat (2) @(posedge mclk);
        #1;
        chk("goto", instr_pointer, 12'ha34);
        chk("rom", rom_addr, 12'ha34);
    endtask
    task automatic t_read();
        logic [11:0] p;
        logic [3:0]  ea[4] = '{4'h0, 4'he, 4'he, 4'hc};
        logic [3:0]  el[4] = '{4'h0, 4'h0, 4'hd, 4'hc};
        for (int a = 0; a < 4; a++) begin
            p = instr_pointer;
            step(3'h5, 12'h00b, 4'(a));
            chk("seq", instr_pointer, p + 12'h001);
            chk("acc", {4'h0, acc_out, aux_out}, {4'h0, ea[a], a > 0 ? 4'hb : 4'h0});
            chk("load", {11'h000, acc_aux_load}, {11'h000, a[0]});
            chk("lat", {4'h0, output_latch_one, output_latch_two},
                {4'h0, el[a], a > 1 ? 4'hb : 4'h0});
        end
    endtask
    initial begin
        #200us;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_ram();
        t_jump();
        t_read();
        conclude();
    end
endmodule // tb_ram_rom_address_generation
bind rraddr_core rraddr_core_asserts i_rraddr_core_asserts (.*);
